// file: pkg/cfsi_defines.vh
`ifndef CFSI_DEFINES_VH
`define CFSI_DEFINES_VH

// Register byte offsets on the 16-bit register port
`define CFSI_OFF_CTRL   4'h0
`define CFSI_OFF_CODE   4'h2
`define CFSI_OFF_BSTAT  4'h4
`define CFSI_OFF_ESTAT  4'h6
`define CFSI_OFF_BMASK  4'h8
`define CFSI_OFF_EMASK  4'ha

// Field positions
`define CFSI_DCC_LSB    0
`define CFSI_DCC_W      5
`define CFSI_HIT_LSB    8
`define CFSI_HIT_W      5
`define CFSI_IC_LSB     0
`define CFSI_IC_W       7
`define CFSI_EV_ERR     0
`define CFSI_EV_WAKE    1
`define CFSI_EV_OVF     2
`define CFSI_EV_FIFO    3
`define CFSI_EV_W       4

// Reset values
`define CFSI_RST_DCC    5'h00
`define CFSI_RST_HIT    5'h00
`define CFSI_RST_MASK8  8'h00
`define CFSI_RST_MASK4  4'h0

// Data compare count limits and compared bit span
`define CFSI_DCC_NONE   5'h00
`define CFSI_DCC_MAX    5'h11
`define CFSI_CMP_BITS   18

// Interrupt code values
`define CFSI_IC_NONE    7'h40
`define CFSI_IC_ERR     7'h41
`define CFSI_IC_WAKE    7'h42
`define CFSI_IC_OVF     7'h43
`define CFSI_IC_FIFO    7'h44
`define CFSI_IC_TXPFX   4'h0
`define CFSI_IC_RXPFX   4'h1

`endif

// file: core/cfsi_interrupt_code_enc.v
`timescale 1ns/100ps
`default_nettype none
`include "cfsi_defines.vh"

module cfsi_interrupt_code_enc
(
    input  wire [7:0]              i_tx_pend,
    input  wire [7:0]              i_rx_pend,
    input  wire [`CFSI_EV_W-1:0]   i_ev_pend,
    output reg  [`CFSI_IC_W-1:0]   o_code
);

    integer i;

    // Error, wake, overflow, fifo events first, then lowest tx buffer, then lowest rx buffer
    always @*
    begin
        o_code = `CFSI_IC_NONE;
        for (i = 7; i >= 0; i = i - 1)
        begin
            if (i_rx_pend[i])
            begin
                o_code = {`CFSI_IC_RXPFX, i[2:0]};
            end
        end
        for (i = 7; i >= 0; i = i - 1)
        begin
            if (i_tx_pend[i])
            begin
                o_code = {`CFSI_IC_TXPFX, i[2:0]};
            end
        end
        if (i_ev_pend[`CFSI_EV_FIFO])
        begin
            o_code = `CFSI_IC_FIFO;
        end
        if (i_ev_pend[`CFSI_EV_OVF])
        begin
            o_code = `CFSI_IC_OVF;
        end
        if (i_ev_pend[`CFSI_EV_WAKE])
        begin
            o_code = `CFSI_IC_WAKE;
        end
        if (i_ev_pend[`CFSI_EV_ERR])
        begin
            o_code = `CFSI_IC_ERR;
        end
    end

endmodule

`default_nettype wire

// file: core/cfsi_top.v
`timescale 1ns/100ps
`default_nettype none
`include "cfsi_defines.vh"

module cfsi_top
(
    input  wire                     i_clk,
    input  wire                     i_reset,
    input  wire [3:0]               i_addr,
    input  wire [15:0]              i_wdata,
    input  wire                     i_wr,
    input  wire                     i_rd,
    output wire [15:0]              o_rdata,
    input  wire [`CFSI_DCC_W-1:0]   i_data_compare_count,
    input  wire                     i_accept_valid,
    input  wire [3:0]               i_accept_filter,
    input  wire [7:0]               i_tx_buf_event,
    input  wire [7:0]               i_rx_buf_event,
    input  wire                     i_error_event,
    input  wire                     i_wake_event,
    input  wire                     i_overflow_event,
    input  wire                     i_fifo_almost_event,
    output wire                     o_irq,
    output wire [`CFSI_IC_W-1:0]    o_interrupt_code,
    output wire [`CFSI_CMP_BITS-1:0] o_data_bit_enable,
    output wire                     o_compare_count_invalid
);

    // Register address match, used by the write strobes
    function cfsi_hit;
        input [3:0] addr;
        input [3:0] off;
        begin
            cfsi_hit = (addr == off);
        end
    endfunction

    // Whether compared bit idx is enabled for count cnt
    function cfsi_bit_on;
        input [`CFSI_DCC_W-1:0] cnt;
        input integer           idx;
        begin
            if (cnt > `CFSI_DCC_MAX)
            begin
                cfsi_bit_on = 1'b0;
            end
            else if (cnt == `CFSI_DCC_MAX)
            begin
                cfsi_bit_on = 1'b1;
            end
            else
            begin
                cfsi_bit_on = (idx < cnt);
            end
        end
    endfunction

    reg  [`CFSI_DCC_W-1:0]    dcc_ff;
    reg  [`CFSI_HIT_W-1:0]    hit_ff;
    reg  [`CFSI_IC_W-1:0]     interrupt_code_ff;
    reg  [7:0]                tx_pend_ff;
    reg  [7:0]                rx_pend_ff;
    reg  [`CFSI_EV_W-1:0]     ev_pend_ff;
    reg  [7:0]                tx_mask_ff;
    reg  [7:0]                rx_mask_ff;
    reg  [`CFSI_EV_W-1:0]     ev_mask_ff;
    reg                       irq_ff;
    reg  [15:0]               rdata_ff;
    reg  [`CFSI_CMP_BITS-1:0] bit_en_ff;
    reg                       cnt_bad_ff;

    wire [7:0]                nxt_tx_pend;
    wire [7:0]                nxt_rx_pend;
    wire [`CFSI_EV_W-1:0]     nxt_ev_pend;
    reg  [15:0]               nxt_rdata;
    wire [`CFSI_CMP_BITS-1:0] nxt_bit_en;
    wire [`CFSI_IC_W-1:0]     nxt_interrupt_code;
    wire [`CFSI_HIT_W-1:0]    nxt_hit;
    wire                      nxt_cnt_bad;
    wire [`CFSI_EV_W-1:0]     ev_in;
    wire [7:0]                tx_clr;
    wire [7:0]                rx_clr;
    wire [`CFSI_EV_W-1:0]     ev_clr;
    wire [7:0]                tx_act;
    wire [7:0]                rx_act;
    wire [`CFSI_EV_W-1:0]     ev_act;
    wire [15:0]               ctrl_word;
    wire [15:0]               code_word;
    wire [15:0]               bstat_word;
    wire [15:0]               estat_word;
    wire [15:0]               bmask_word;
    wire [15:0]               emask_word;
    wire                      wr_bstat;
    wire                      wr_estat;
    wire                      wr_bmask;
    wire                      wr_emask;
    wire                      any_pend;
    genvar                    g;

    // Event inputs gathered in status bit order
    assign ev_in[`CFSI_EV_ERR]  = i_error_event;
    assign ev_in[`CFSI_EV_WAKE] = i_wake_event;
    assign ev_in[`CFSI_EV_OVF]  = i_overflow_event;
    assign ev_in[`CFSI_EV_FIFO] = i_fifo_almost_event;

    // Write strobes for the status and mask words
    assign wr_bstat = i_wr & cfsi_hit(i_addr, `CFSI_OFF_BSTAT);
    assign wr_estat = i_wr & cfsi_hit(i_addr, `CFSI_OFF_ESTAT);
    assign wr_bmask = i_wr & cfsi_hit(i_addr, `CFSI_OFF_BMASK);
    assign wr_emask = i_wr & cfsi_hit(i_addr, `CFSI_OFF_EMASK);

    // Write-one-to-clear bits, only on a status write
    assign tx_clr = wr_bstat ? i_wdata[7:0] : 8'h00;
    assign rx_clr = wr_bstat ? i_wdata[15:8] : 8'h00;
    assign ev_clr = wr_estat ? i_wdata[`CFSI_EV_W-1:0] : {`CFSI_EV_W{1'b0}};

    // Buffer flags; a new event beats a same-cycle clear
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_buf
            assign nxt_tx_pend[g] = i_tx_buf_event[g] | (tx_pend_ff[g] & ~tx_clr[g]);
            assign nxt_rx_pend[g] = i_rx_buf_event[g] | (rx_pend_ff[g] & ~rx_clr[g]);
        end
    endgenerate

    // Event flags, same set-over-clear rule
    generate
        for (g = 0; g < `CFSI_EV_W; g = g + 1)
        begin : g_ev
            assign nxt_ev_pend[g] = ev_in[g] | (ev_pend_ff[g] & ~ev_clr[g]);
        end
    endgenerate

    // Flags that are allowed to interrupt
    assign tx_act = nxt_tx_pend & tx_mask_ff;
    assign rx_act = nxt_rx_pend & rx_mask_ff;
    assign ev_act = nxt_ev_pend & ev_mask_ff;

    // Any enabled pending flag raises the interrupt
    assign any_pend = (|tx_act) | (|rx_act) | (|ev_act);

    // Code for the highest-priority enabled pending source
    cfsi_interrupt_code_enc u_enc
    (
        .i_tx_pend (tx_act),
        .i_rx_pend (rx_act),
        .i_ev_pend (ev_act),
        .o_code    (nxt_interrupt_code)
    );

    // Per-bit compare enables for the data bytes
    generate
        for (g = 0; g < `CFSI_CMP_BITS; g = g + 1)
        begin : g_cmp
            assign nxt_bit_en[g] = cfsi_bit_on(dcc_ff, g);
        end
    endgenerate

    // Capture compare count setting from the mode logic
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            dcc_ff <= `CFSI_RST_DCC;
        end
        else
        begin
            dcc_ff <= i_data_compare_count;
        end
    end

    // Counts past the top code are flagged, never compared
    assign nxt_cnt_bad = (dcc_ff > `CFSI_DCC_MAX);

    // Compare span and invalid flag from the held count
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            bit_en_ff  <= {`CFSI_CMP_BITS{1'b0}};
            cnt_bad_ff <= 1'b0;
        end
        else
        begin
            bit_en_ff  <= nxt_bit_en;
            cnt_bad_ff <= nxt_cnt_bad;
        end
    end

    // Filter number widened; reserved upper codes never appear
    assign nxt_hit = {1'b0, i_accept_filter};

    // Number of the filter that took the last accepted frame
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            hit_ff <= `CFSI_RST_HIT;
        end
        else if (i_accept_valid)
        begin
            hit_ff <= nxt_hit;
        end
    end

    // Pending flags, set by events and cleared by software
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_pend_ff <= 8'h00;
            rx_pend_ff <= 8'h00;
            ev_pend_ff <= 4'h0;
        end
        else
        begin
            tx_pend_ff <= nxt_tx_pend;
            rx_pend_ff <= nxt_rx_pend;
            ev_pend_ff <= nxt_ev_pend;
        end
    end

    // Code and line follow the next flags, so they move together
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            interrupt_code_ff <= `CFSI_IC_NONE;
            irq_ff   <= 1'b0;
        end
        else
        begin
            interrupt_code_ff <= nxt_interrupt_code;
            irq_ff   <= any_pend;
        end
    end

    // Software written buffer interrupt masks
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_mask_ff <= `CFSI_RST_MASK8;
            rx_mask_ff <= `CFSI_RST_MASK8;
        end
        else if (wr_bmask)
        begin
            tx_mask_ff <= i_wdata[7:0];
            rx_mask_ff <= i_wdata[15:8];
        end
    end

    // Software written event interrupt masks
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ev_mask_ff <= `CFSI_RST_MASK4;
        end
        else if (wr_emask)
        begin
            ev_mask_ff <= i_wdata[`CFSI_EV_W-1:0];
        end
    end

    // Register words as software sees them; spare bits tie to zero
    assign ctrl_word  = {11'h000, dcc_ff};
    assign code_word  = {3'h0, hit_ff, 1'b0, interrupt_code_ff};
    assign bstat_word = {rx_pend_ff, tx_pend_ff};
    assign estat_word = {12'h000, ev_pend_ff};
    assign bmask_word = {rx_mask_ff, tx_mask_ff};
    assign emask_word = {12'h000, ev_mask_ff};

    // Read mux; unused and unmapped bits give zero
    always @*
    begin
        nxt_rdata = 16'h0000;
        case (i_addr)
            `CFSI_OFF_CTRL:
            begin
                nxt_rdata = ctrl_word;
            end
            `CFSI_OFF_CODE:
            begin
                nxt_rdata = code_word;
            end
            `CFSI_OFF_BSTAT:
            begin
                nxt_rdata = bstat_word;
            end
            `CFSI_OFF_ESTAT:
            begin
                nxt_rdata = estat_word;
            end
            `CFSI_OFF_BMASK:
            begin
                nxt_rdata = bmask_word;
            end
            `CFSI_OFF_EMASK:
            begin
                nxt_rdata = emask_word;
            end
            default:
            begin
                nxt_rdata = 16'h0000;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rdata_ff <= 16'h0000;
        end
        else if (i_rd)
        begin
            rdata_ff <= nxt_rdata;
        end
        else
        begin
            rdata_ff <= 16'h0000;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata                 = rdata_ff;
    assign o_irq                   = irq_ff;
    assign o_interrupt_code        = interrupt_code_ff;
    assign o_data_bit_enable       = bit_en_ff;
    assign o_compare_count_invalid = cnt_bad_ff;

endmodule

`default_nettype wire

// file: test/cfsi_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cfsi_monitor
(
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [3:0]  i_addr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [4:0]  i_data_compare_count,
    input wire logic        o_irq,
    input wire logic [6:0]  o_interrupt_code,
    input wire logic [17:0] o_data_bit_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Read data only in the cycle after a read
    rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    // Unused bits of both registers
    ctrl_pad_a: assert property ($past(i_rd) && $past(i_addr) == 4'h0
        |-> o_rdata[15:5] == 0)
        else $error("control pad bits set");
    code_pad_a: assert property ($past(i_rd) && $past(i_addr) == 4'h2 |-> !o_rdata[7])
        else $error("code pad bit set");
    hit_range_a: assert property ($past(i_rd) && $past(i_addr) == 4'h2
        |-> o_rdata[15:12] == 0)
        else $error("filter hit out of range");
    // Compare span follows the count two edges on
    dcc_none_a: assert property ($past(i_data_compare_count, 2) == 5'h00
        |-> o_data_bit_enable == 0)
        else $error("bits compared at count zero");
    dcc_full_a: assert property ($past(i_data_compare_count, 2) == 5'h11
        |-> &o_data_bit_enable)
        else $error("full span not enabled");
    // Code values while idle and pending
    code_idle_a: assert property (!o_irq |-> o_interrupt_code == 7'h40)
        else $error("idle code wrong");
    code_set_a: assert property (o_irq |-> o_interrupt_code <= 7'h0f ||
        (o_interrupt_code >= 7'h41 && o_interrupt_code <= 7'h44))
        else $error("pending code not legal");
    cover property (o_irq && o_interrupt_code == 7'h0f);
    cover property (o_irq && o_interrupt_code == 7'h44);
    cover property ($past(i_rd) && o_rdata[12:8] == 5'h0f);
endmodule
bind cfsi_top cfsi_monitor i_mon (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_data_compare_count(i_data_compare_count),
    .o_irq(o_irq), .o_interrupt_code(o_interrupt_code), .o_data_bit_enable(o_data_bit_enable));
`default_nettype wire

// file: test/cfsi_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cfsi_top_tb;
    logic        clk = 0;
    logic        reset = 1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 0;
    logic        rd = 0;
    logic [4:0]  dcc = 5'h00;
    logic        acc = 0;
    logic [3:0]  filt = 4'h0;
    logic [19:0] ev = 20'h00000;
    wire  [15:0] rdata;
    wire         irq;
    wire  [6:0]  interrupt_code;
    wire  [17:0] den;
    wire         inv;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          cl [6] = '{0, 1, 16, 17, 18, 31};
    logic [6:0]  ec;
    logic [17:0] eb;

    always #25 clk = ~clk;

    cfsi_top i_dut (.i_clk(clk), .i_reset(reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_data_compare_count(dcc), .i_accept_valid(acc),
        .i_accept_filter(filt), .i_tx_buf_event(ev[7:0]), .i_rx_buf_event(ev[15:8]),
        .i_error_event(ev[16]), .i_wake_event(ev[17]), .i_overflow_event(ev[18]),
        .i_fifo_almost_event(ev[19]), .o_irq(irq), .o_interrupt_code(interrupt_code),
        .o_data_bit_enable(den), .o_compare_count_invalid(inv));

    // Compare and count
    task chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle write strobe
    task bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
        #1;
    endtask

    // Read strobe, data checked in the next cycle
    task bus_rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk("rdata", rdata, e);
    endtask

    // Event pulse of one cycle
    task pulse(input int k);
        @(posedge clk);
        ev <= 20'h1 << k;
        @(posedge clk);
        ev <= 20'h0;
        #1;
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            complete_run;
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 0;
        bus_rd(4'h0, 16'h0000);
        bus_rd(4'h2, 16'h0040);
        chk("irq", irq, 0);
        bus_rd(4'hc, 16'h0000);
        $display("test reset done");
        // Count codes at the edges of the legal range
        foreach (cl[i])
        begin
            @(posedge clk);
            dcc <= cl[i][4:0];
            repeat (3) @(posedge clk);
            #1;
            eb = (cl[i] == 17) ? 18'h3ffff : (18'h1 << cl[i]) - 1;
            if (cl[i] == 0 || cl[i] > 17)
                eb = 18'h0;
            chk("bit_enable", den, eb);
            chk("invalid", inv, cl[i] > 17);
            bus_rd(4'h0, {11'h0, cl[i][4:0]});
        end
        bus_wr(4'h0, 16'hffff);
        bus_rd(4'h0, 16'h001f);
        $display("test compare count done");
        // Filter hit at both ends
        for (int f = 15; f >= 0; f -= 15)
        begin
            @(posedge clk);
            acc <= 1;
            filt <= f[3:0];
            @(posedge clk);
            acc <= 0;
            bus_rd(4'h2, {4'h0, f[3:0], 8'h40});
        end
        $display("test filter hit done");
        // Every buffer and event source in turn
        bus_wr(4'h8, 16'hffff);
        bus_wr(4'ha, 16'h000f);
        for (int k = 0; k < 20; k++)
        begin
            ec = (k < 16) ? k[6:0] : 7'(k + 49);
            pulse(k);
            chk("code", interrupt_code, ec);
            chk("irq", irq, 1);
            bus_rd(4'h2, {9'h0, ec});
            if (k < 16)
                bus_wr(4'h4, 16'h1 << k);
            else
                bus_wr(4'h6, 16'h1 << (k - 16));
            chk("code", interrupt_code, 7'h40);
        end
        // Masked source latches but stays silent
        bus_wr(4'h8, 16'hfffe);
        pulse(0);
        chk("code", interrupt_code, 7'h40);
        bus_rd(4'h4, 16'h0001);
        $display("test interrupt codes done");
        complete_run;
    end
endmodule
`default_nettype wire
